//--- core/exec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface exec_if;
   nibble_xor_pkg::op_e op;
   logic [nibble_xor_pkg::DATA_W-1:0] acc;
   logic [nibble_xor_pkg::DATA_W-1:0] file_data;
   logic [nibble_xor_pkg::DATA_W-1:0] literal;
   logic [nibble_xor_pkg::DATA_W-1:0] result;
   logic zero;
   logic touches_zero;
   modport ctrl (output op, acc, file_data, literal,
                 input result, zero, touches_zero);
   modport unit (input op, acc, file_data, literal,
                 output result, zero, touches_zero);
endinterface
`default_nettype wire

//--- core/nibble_swap_xor_exec.sv
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_xor_exec (
   input wire logic i_ref_clk, // Core clock, 40 MHz
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire logic i_instr_valid, // Instruction word present this cycle
   input wire logic [13:0] i_instr, // Instruction word
   input wire logic [7:0] i_file_rdata, // Data of addressed file register
   output logic [7:0] o_acc, // Accumulator
   output logic [6:0] o_file_addr, // File register write address
   output logic [7:0] o_file_wdata, // File register write data
   output logic o_file_we, // File register write pulse
   output logic o_zero_we, // Zero flag update pulse
   output logic o_zero, // Zero flag value to store
   output logic o_done // Instruction of this slice retired
);
   localparam int DB = nibble_xor_pkg::DEST_BIT;
   localparam int DW = nibble_xor_pkg::DATA_W;
   localparam int AW = nibble_xor_pkg::ADDR_W;
   localparam int NW = nibble_xor_pkg::NIB_W;

   exec_if ex ();
   nibble_xor_pkg::op_e op;
   logic take;
   logic to_file;

   assign op = i_instr_valid ? nibble_xor_pkg::decode_op(i_instr)
                             : nibble_xor_pkg::OP_NONE;
   assign take = (op != nibble_xor_pkg::OP_NONE);
   // Literal form has no destination bit; bit 7 is literal data there
   assign to_file = i_instr[DB] &&
                    (op != nibble_xor_pkg::OP_LITERAL_XOR); // RULE_02 RULE_04

   assign ex.op = op;
   assign ex.acc = o_acc;
   assign ex.file_data = i_file_rdata;
   assign ex.literal = i_instr[DW-1:0];

   nibble_xor_alu u_alu (
      .ex (ex.unit)
   );

   // Accumulator update
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_acc <= nibble_xor_pkg::ACC_RESET;
      end else if (take && !to_file) begin
         o_acc <= ex.result; // RULE_02 RULE_04
      end
   end

   // File register write-back
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_file_we <= 1'b0;
         o_file_addr <= nibble_xor_pkg::ADDR_RESET;
         o_file_wdata <= nibble_xor_pkg::DATA_ZERO;
      end else begin
         o_file_we <= take && to_file; // RULE_02 RULE_04
         if (take && to_file) begin
            o_file_addr <= i_instr[AW-1:0];
            o_file_wdata <= ex.result;
         end
      end
   end

   // Zero flag; exchange leaves it alone
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_zero_we <= 1'b0;
         o_zero <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_zero_we <= take && ex.touches_zero; // RULE_01 RULE_03 RULE_05
         o_done <= take;
         if (take && ex.touches_zero) begin
            o_zero <= ex.zero; // RULE_03 RULE_05
         end
      end
   end

   // Nibble exchange: checked one cycle after decode, once outputs settle
   swap_result_a: assert property ( // RULE_01
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_NIBBLE_EXCHANGE && !i_instr[DB]) |=>
      (o_acc == {$past(i_file_rdata[NW-1:0]), $past(i_file_rdata[DW-1:NW])})
      && !o_zero_we && !o_file_we)
      else $error("nibble exchange result or flag wrong");

   swap_to_file_a: assert property ( // RULE_01
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_NIBBLE_EXCHANGE && i_instr[DB]) |=>
      (o_file_wdata == {$past(i_file_rdata[NW-1:0]),
                        $past(i_file_rdata[DW-1:NW])})
      && !o_zero_we && $stable(o_acc))
      else $error("nibble exchange write-back wrong");

   swap_flags_a: assert property ( // RULE_01
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_NIBBLE_EXCHANGE) |=>
      !o_zero_we && $stable(o_zero))
      else $error("nibble exchange touched the zero flag");

   zero_source_a: assert property ( // RULE_01
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $changed(o_zero) |-> o_zero_we)
      else $error("zero value moved without an update pulse");

   // Destination select
   dest_select_a: assert property ( // RULE_02
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ((op == nibble_xor_pkg::OP_NIBBLE_EXCHANGE ||
        op == nibble_xor_pkg::OP_FILE_XOR) && i_instr[DB]) |=>
      o_file_we && o_file_addr == $past(i_instr[AW-1:0]) &&
      $stable(o_acc))
      else $error("destination select to file not honoured");

   dest_acc_a: assert property ( // RULE_02
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ((op == nibble_xor_pkg::OP_NIBBLE_EXCHANGE ||
        op == nibble_xor_pkg::OP_FILE_XOR) && !i_instr[DB]) |=>
      !o_file_we)
      else $error("destination select to accumulator wrote a file");

   acc_source_a: assert property ( // RULE_02
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $changed(o_acc) |-> o_done && !o_file_we)
      else $error("accumulator moved without an accumulator write");

   wdata_source_a: assert property ( // RULE_02
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $changed(o_file_wdata) |-> o_file_we)
      else $error("write data moved without a write pulse");

   addr_source_a: assert property ( // RULE_02
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $changed(o_file_addr) |-> o_file_we)
      else $error("write address moved without a write pulse");

   // Literal xor
   lit_xor_a: assert property ( // RULE_03
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_LITERAL_XOR) |=>
      o_acc == ($past(o_acc) ^ $past(i_instr[DW-1:0])) && o_zero_we &&
      o_zero == (o_acc == nibble_xor_pkg::DATA_ZERO))
      else $error("literal xor result or zero flag wrong");

   lit_flags_a: assert property ( // RULE_03
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_LITERAL_XOR) |=>
      o_zero_we && o_done)
      else $error("literal xor did not update the zero flag");

   lit_no_file_a: assert property ( // RULE_04
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_LITERAL_XOR) |=>
      !o_file_we && $stable(o_file_addr) && $stable(o_file_wdata))
      else $error("literal xor wrote a file register");

   // Bit 7 is literal data here, so it must flip the accumulator bit
   lit_bit7_a: assert property ( // RULE_04
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_LITERAL_XOR && i_instr[DB]) |=>
      o_acc[DB] != $past(o_acc[DB]))
      else $error("literal xor bit 7 taken as destination");

   // File xor
   file_xor_a: assert property ( // RULE_05
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_FILE_XOR && i_instr[DB]) |=>
      o_file_wdata == ($past(o_acc) ^ $past(i_file_rdata)) && o_zero_we &&
      o_zero == (o_file_wdata == nibble_xor_pkg::DATA_ZERO))
      else $error("file xor result or zero flag wrong");

   file_xor_acc_a: assert property ( // RULE_05
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_FILE_XOR && !i_instr[DB]) |=>
      o_acc == ($past(o_acc) ^ $past(i_file_rdata)) && o_zero_we &&
      o_zero == (o_acc == nibble_xor_pkg::DATA_ZERO))
      else $error("file xor to accumulator wrong");

   file_xor_keep_a: assert property ( // RULE_05
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_FILE_XOR && i_instr[DB]) |=>
      $stable(o_acc) && o_zero_we)
      else $error("file xor to file disturbed the accumulator");

   // Retire pulse and idle behaviour
   done_pulse_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op != nibble_xor_pkg::OP_NONE) |=> o_done)
      else $error("executed instruction not retired");

   done_cause_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_done |-> $past(take))
      else $error("retire pulse without an instruction");

   idle_quiet_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (op == nibble_xor_pkg::OP_NONE) |=>
      !o_done && !o_file_we && !o_zero_we && $stable(o_acc))
      else $error("ignored word changed an output");

   we_with_done_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_file_we |-> o_done)
      else $error("file write pulse without retire");

   zero_with_done_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_zero_we |-> o_done)
      else $error("zero update pulse without retire");
endmodule // nibble_swap_xor_exec
`default_nettype wire

//--- core/nibble_xor_alu.sv
`timescale 1ns/1ps
`default_nettype none
module nibble_xor_alu (
   exec_if.unit ex // Operands in, result out
);
   localparam int NW = nibble_xor_pkg::NIB_W;
   localparam int DW = nibble_xor_pkg::DATA_W;

   always_comb begin
      ex.result = nibble_xor_pkg::DATA_ZERO;
      ex.touches_zero = 1'b0;
      case (ex.op)
         nibble_xor_pkg::OP_NIBBLE_EXCHANGE: begin
            ex.result = {ex.file_data[NW-1:0], ex.file_data[DW-1:NW]}; // RULE_01
         end
         nibble_xor_pkg::OP_LITERAL_XOR: begin
            ex.result = ex.acc ^ ex.literal; // RULE_03
            ex.touches_zero = 1'b1; // RULE_03
         end
         nibble_xor_pkg::OP_FILE_XOR: begin
            ex.result = ex.acc ^ ex.file_data; // RULE_05
            ex.touches_zero = 1'b1; // RULE_05
         end
         default: begin
            ex.result = nibble_xor_pkg::DATA_ZERO;
         end
      endcase
      ex.zero = (ex.result == nibble_xor_pkg::DATA_ZERO);
   end
endmodule // nibble_xor_alu
`default_nettype wire

//--- core/nibble_xor_pkg.sv
// Operation
// RULE_01: Nibble exchange swaps file register nibbles; status flags stay unchanged.
// RULE_02: Instruction bit 7 picks destination: 0 accumulator, 1 file register.
// RULE_03: Literal XOR combines accumulator with low byte literal; only zero flag updates.
// RULE_04: Literal XOR always writes the accumulator, never a file register.
// RULE_05: File XOR combines accumulator with file register; zero flag; destination by bit 7.
`default_nettype none
package nibble_xor_pkg;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int OPC_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int NIB_W = 4;
   localparam logic [5:0] NIBBLE_EXCHANGE_OPC = 6'h0E;
   localparam logic [5:0] FILE_XOR_OPC = 6'h06;
   localparam logic [5:0] LITERAL_XOR_OPC = 6'h3A;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_NIBBLE_EXCHANGE = 2'b01,
      OP_LITERAL_XOR = 2'b10,
      OP_FILE_XOR = 2'b11
   } op_e;

   function automatic op_e decode_op(input logic [INSTR_W-1:0] instr);
      logic [5:0] opc;
      opc = instr[INSTR_W-1:OPC_LSB];
      if (opc == NIBBLE_EXCHANGE_OPC) begin
         return OP_NIBBLE_EXCHANGE;
      end else if (opc == LITERAL_XOR_OPC) begin
         return OP_LITERAL_XOR;
      end else if (opc == FILE_XOR_OPC) begin
         return OP_FILE_XOR;
      end
      return OP_NONE;
   endfunction
endpackage
`default_nettype wire

//--- testbench/nibble_swap_xor_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_xor_exec_bench;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_instr_valid = 1'b0;
   logic [13:0] i_instr = 14'h0000;
   logic [7:0] i_file_rdata = 8'h00;
   logic [7:0] o_acc;
   logic [7:0] o_file_wdata;
   logic [6:0] o_file_addr;
   logic o_file_we, o_zero_we, o_zero, o_done;
   int n_errors = 0;
   int samples_checked = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   nibble_swap_xor_exec dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_file_rdata(i_file_rdata), .o_acc(o_acc), .o_file_addr(o_file_addr),
      .o_file_wdata(o_file_wdata), .o_file_we(o_file_we),
      .o_zero_we(o_zero_we), .o_zero(o_zero), .o_done(o_done));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Read data flips after the sample so a late read is caught
   task automatic run(input logic [13:0] ins, input logic [7:0] rd,
                      input logic v);
      @(posedge i_ref_clk);
      i_instr_valid <= v;
      i_instr <= ins;
      i_file_rdata <= rd;
      @(posedge i_ref_clk);
      i_instr_valid <= 1'b0;
      i_file_rdata <= ~rd;
      #1;
   endtask

   task automatic expect_out(input logic [7:0] a, input logic we,
      input logic [6:0] ad, input logic [7:0] wd, input logic zwe,
      input logic z, input logic dn);
      chk(o_acc, a);
      chk({7'h00, o_file_we}, {7'h00, we});
      if (we) begin
         chk({1'b0, o_file_addr}, {1'b0, ad});
         chk(o_file_wdata, wd);
      end
      chk({7'h00, o_zero_we}, {7'h00, zwe});
      if (zwe) begin
         chk({7'h00, o_zero}, {7'h00, z});
      end
      chk({7'h00, o_done}, {7'h00, dn});
   endtask

   task automatic t_swap;
      run(14'h0E95, 8'hA5, 1'b1);
      expect_out(8'h00, 1'b1, 7'h15, 8'h5A, 1'b0, 1'b0, 1'b1);
      run(14'h0E15, 8'h3C, 1'b1);
      expect_out(8'hC3, 1'b0, 7'h15, 8'h00, 1'b0, 1'b0, 1'b1);
      $display("swap test done");
   endtask

   // Bit 7 of the literal set, so a misread destination would show
   task automatic t_lxor;
      run(14'h3AAF, 8'h77, 1'b1);
      expect_out(8'h6C, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, 1'b1);
      run(14'h3A6C, 8'h77, 1'b1);
      expect_out(8'h00, 1'b0, 7'h00, 8'h00, 1'b1, 1'b1, 1'b1);
      run(14'h3AB5, 8'h00, 1'b1);
      expect_out(8'hB5, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, 1'b1);
      $display("literal xor test done");
   endtask

   task automatic t_fxor;
      run(14'h0622, 8'hAF, 1'b1);
      expect_out(8'h1A, 1'b0, 7'h22, 8'h00, 1'b1, 1'b0, 1'b1);
      run(14'h06FF, 8'h1A, 1'b1);
      expect_out(8'h1A, 1'b1, 7'h7F, 8'h00, 1'b1, 1'b1, 1'b1);
      $display("file xor test done");
   endtask

   task automatic t_ignore;
      run(14'h0E95, 8'hA5, 1'b0);
      expect_out(8'h1A, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      run(14'h0066, 8'h55, 1'b1);
      expect_out(8'h1A, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      $display("ignore test done");
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1;
      expect_out(8'h00, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      t_swap();
      t_lxor();
      t_fxor();
      t_ignore();
      tally_and_finish();
   end

   initial begin
      repeat (2000) @(posedge i_ref_clk);
      n_errors++;
      $display("MISMATCH t=%0t run hung", $time);
      tally_and_finish();
   end
endmodule // nibble_swap_xor_exec_bench
`default_nettype wire
